// >>> dv/flash_erase_props.sv
// Concurrent checks on the ports of the erase command sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/100ps
module flash_erase_props #(
  parameter int BLK_P_OP = 1,
  parameter int BLK_P_BUS = 1,
  parameter int BLK_D_OP = 1,
  parameter int BLK_D_BUS = 1,
  parameter int SEC_OP = 1,
  parameter int SEC_BUS = 1,
  parameter int OP_DIV = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire flash_erase_pkg::axi_resp_t s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic erase_active,
  input wire logic verify_active,
  input wire logic erase_sector,
  input wire logic erase_eeprom,
  input wire logic [23:0] erase_addr,
  input wire logic secured,
  input wire logic [1:0] security_state_field,
  input wire logic backdoor_unsecured
);
  import flash_erase_pkg::*;

  logic [31:0] erase_len_reg;
  logic [31:0] verify_len_reg;
  logic [31:0] erase_exp;
  logic [31:0] verify_exp;

  // Phase lengths counted here, since repetitions cannot take parameters
  assign erase_exp = erase_sector ? 32'(SEC_OP * OP_DIV) :
    erase_eeprom ? 32'(BLK_D_OP * OP_DIV) : 32'(BLK_P_OP * OP_DIV);
  assign verify_exp = erase_sector ? 32'(SEC_BUS) :
    erase_eeprom ? 32'(BLK_D_BUS) : 32'(BLK_P_BUS);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      erase_len_reg <= '0;
      verify_len_reg <= '0;
    end else begin
      erase_len_reg <= erase_active ? erase_len_reg + 1 : '0;
      verify_len_reg <= verify_active ? verify_len_reg + 1 : '0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  erase_len_a: assert property (
    $fell(erase_active) |-> erase_len_reg == erase_exp)
    else $error("erase phase length wrong");
  verify_len_a: assert property (
    $fell(verify_active) |-> verify_len_reg == verify_exp)
    else $error("verify phase length wrong");
  erase_then_verify_a: assert property (
    $fell(erase_active) |-> verify_active)
    else $error("verify did not follow erase");
  verify_cause_a: assert property (
    $rose(verify_active) |-> $past(erase_active))
    else $error("verify started without erase");
  phases_apart_a: assert property (
    !(erase_active && verify_active))
    else $error("erase and verify overlap");
  target_stable_a: assert property (
    verify_active |-> $stable(erase_addr) && $stable(erase_sector))
    else $error("erase target changed mid operation");
  secured_decode_a: assert property (
    $past(nrst) |-> secured == !($past(backdoor_unsecured) ||
      $past(security_state_field) == 2'b10))
    else $error("security decode wrong");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  write_close_a: assert property (
    s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response timing wrong");
  read_close_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");

  cover property ($fell(verify_active) && erase_sector);
  cover property ($fell(verify_active) && erase_eeprom);
  cover property ($fell(verify_active) && !erase_sector && !erase_eeprom);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : flash_erase_props

bind flash_erase_command_sequencer flash_erase_props #(
  .BLK_P_OP(BLK_P_OP), .BLK_P_BUS(BLK_P_BUS), .BLK_D_OP(BLK_D_OP),
  .BLK_D_BUS(BLK_D_BUS), .SEC_OP(SEC_OP), .SEC_BUS(SEC_BUS),
  .OP_DIV(OP_DIV)
) flash_erase_props_inst (
  .clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .erase_active, .verify_active, .erase_sector, .erase_eeprom,
  .erase_addr, .secured, .security_state_field, .backdoor_unsecured
);

// >>> dv/tb_top.sv
// Self-checking bench for the erase command sequencer.
// Assumes the checker is bound in from its own file; counts are shortened.
`timescale 1ns/100ps
`include "flash_erase_params.svh"
module tb_top;
  import flash_erase_pkg::*;
  localparam int OPD = 2;
  localparam int SOP = 4, SBUS = 3, POP = 5, PBUS = 6, DOP = 3, DBUS = 2;
  localparam int LSEC = SOP * OPD + SBUS, LPBLK = POP * OPD + PBUS;
  localparam int LDBLK = DOP * OPD + DBUS;
  localparam logic [7:0] A_STAT = 8'({`IDX_MEMORY_STATUS, 2'b00});
  localparam logic [7:0] A_IDX = 8'({`IDX_COMMAND_PARAM_INDEX, 2'b00});
  localparam logic [7:0] A_DAT = 8'({`IDX_COMMAND_PARAM_DATA, 2'b00});
  localparam logic [7:0] A_SEC = 8'({`IDX_SECURITY, 2'b00});
  logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, mode_allows_erase, pflash_protect_any;
  logic eeprom_protect_any, verify_error, verify_uncorrectable;
  logic backdoor_unsecured, erase_active, verify_active, erase_sector;
  logic erase_eeprom, secured;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] security_state_field;
  logic [23:0] erase_addr;
  axi_resp_t s_axi_bresp, s_axi_rresp;
  int n_fail = 0, comparisons = 0, cycles = 0, busy_cnt = 0;

  flash_erase_command_sequencer #(
    .BLK_P_OP(POP), .BLK_P_BUS(PBUS), .BLK_D_OP(DOP), .BLK_D_BUS(DBUS),
    .SEC_OP(SOP), .SEC_BUS(SBUS), .OP_DIV(OPD)
  ) flash_erase_command_sequencer_inst (
    .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mode_allows_erase, .pflash_protect_any,
    .eeprom_protect_any, .verify_error, .verify_uncorrectable,
    .security_state_field, .backdoor_unsecured, .erase_active,
    .verify_active, .erase_sector, .erase_eeprom, .erase_addr, .secured
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Busy cycles are counted here so that bus traffic can run meanwhile
  always @(posedge clk) begin
    busy_cnt <= busy_cnt + int'(erase_active || verify_active);
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Every bus task starts on a fresh edge, so no signal is driven twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output axi_resp_t r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Waits for the answer; only the bench timeout ends a hung write
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output axi_resp_t r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    axi_resp_t r;
    wr(a, d, r);
  endtask : put

  task automatic rd_exp(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    axi_resp_t r;
    logic [31:0] d;
    rd(a, d, r);
    check(n, d, e);
  endtask : rd_exp

  task automatic load(input logic [7:0] code, input logic [23:0] ad,
                      input logic [2:0] ix);
    put(A_IDX, 32'h0);
    put(A_DAT, {16'h0, code, ad[23:16]});
    put(A_IDX, 32'h1);
    put(A_DAT, {16'h0, ad[15:0]});
    put(A_IDX, {29'h0, ix});
  endtask : load

  task automatic regs_scenario();
    axi_resp_t r;
    logic [31:0] d;
    rd_exp("status", A_STAT, 32'h80);
    rd_exp("index", A_IDX, 32'h0);
    put(A_IDX, 32'hFFFF_FFFF);
    rd_exp("index", A_IDX, 32'h7);
    wr(8'h04, 32'h1, r);
    check("write resp", 32'(r), 32'(RESP_SLVERR));
    rd(8'h04, d, r);
    check("read resp", 32'(r), 32'(RESP_SLVERR));
    check("read data", d, 32'h0);
  endtask : regs_scenario

  task automatic error_scenario();
    logic [7:0] code [8] = '{8'h0A, 8'h09, 8'h09, 8'h0A, 8'h09, 8'h05,
                             8'h09, 8'h09};
    logic [23:0] ad [8] = '{24'h801000, 24'h800000, 24'h200000, 24'h800002,
                            24'h100001, 24'h800000, 24'h800000, 24'h100000};
    logic [7:0] md = 8'hFD;
    logic [7:0] pp = 8'h40;
    logic [7:0] ep = 8'h80;
    for (int i = 0; i < 8; i++) begin
      load(code[i], ad[i], i == 0 ? 3'h0 : 3'h1);
      mode_allows_erase <= md[i];
      pflash_protect_any <= pp[i];
      eeprom_protect_any <= ep[i];
      put(A_STAT, 32'h80);
      check("erase started", 32'(erase_active), 32'h0);
      rd_exp("stat", A_STAT, i < 6 ? 32'hA0 : 32'h90);
      put(A_STAT, 32'h30);
      rd_exp("status", A_STAT, 32'h80);
    end
    mode_allows_erase <= 1'b1;
    pflash_protect_any <= 1'b0;
    eeprom_protect_any <= 1'b0;
  endtask : error_scenario

  task automatic run_cmd(input logic [7:0] code, input logic [23:0] ad,
                         input logic ve, vu, dat, input int len,
                         input logic [31:0] st);
    int b0;
    load(code, ad, 3'h1);
    verify_error <= ve;
    verify_uncorrectable <= vu;
    b0 = busy_cnt;
    put(A_STAT, 32'h80);
    check("erase started", 32'(erase_active), 32'h1);
    check("erase target", {6'h0, erase_sector, erase_eeprom, erase_addr},
          {6'h0, code == 8'h0A, dat, ad});
    // Index write lands while busy and must be dropped
    put(A_IDX, 32'h5);
    forever begin
      @(posedge clk);
      if (!erase_active && !verify_active) break;
    end
    check("busy cycles", 32'(busy_cnt - b0), 32'(len));
    verify_error <= 1'b0;
    verify_uncorrectable <= 1'b0;
    rd_exp("status", A_STAT, st);
    rd_exp("index", A_IDX, 32'h1);
  endtask : run_cmd

  task automatic security_scenario();
    logic [2:0] e;
    for (int i = 0; i < 8; i++) begin
      security_state_field <= 2'(i);
      backdoor_unsecured <= i[2];
      e[1:0] = i[2] ? 2'b10 : 2'(i);
      e[2] = e[1:0] != 2'b10;
      rd_exp("security", A_SEC, {29'h0, e});
      check("secured", 32'(secured), 32'(e[2]));
    end
  endtask : security_scenario

  initial begin
    nrst = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    mode_allows_erase = 1'b1;
    pflash_protect_any = 1'b0;
    eeprom_protect_any = 1'b0;
    verify_error = 1'b0;
    verify_uncorrectable = 1'b0;
    security_state_field = 2'b00;
    backdoor_unsecured = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    regs_scenario();
    error_scenario();
    run_cmd(8'h0A, 24'h801238, 1'b1, 1'b0, 1'b0, LSEC, 32'h82);
    run_cmd(8'h09, 24'h800000, 1'b1, 1'b1, 1'b0, LPBLK, 32'h83);
    run_cmd(8'h09, 24'h100002, 1'b0, 1'b0, 1'b1, LDBLK, 32'h80);
    security_scenario();
    complete_run();
  end
endmodule : tb_top

// >>> hw/flash_erase_command_sequencer.sv
// Erase command sequencer of a non-volatile memory controller with an
// AXI4-Lite register slave. Assumes one clock at 25 MHz, the array itself
// and its verify read path outside, reporting results on plain inputs.
`timescale 1ns/100ps
`include "flash_erase_params.svh"

module flash_erase_command_sequencer #(
  parameter int ADDR_W = 8,
  parameter int NUM_PARAMS = 6,
  parameter logic [23:0] PF_BASE = 24'h800000,
  parameter logic [23:0] PF_SIZE = 24'h010000,
  parameter logic [23:0] EE_BASE = 24'h100000,
  parameter logic [23:0] EE_SIZE = 24'h001000,
  parameter int BLK_P_OP = `ERS_BLK_P_OP_CYCLES,
  parameter int BLK_P_BUS = `ERS_BLK_P_BUS_CYCLES,
  parameter int BLK_D_OP = `ERS_BLK_D_OP_CYCLES,
  parameter int BLK_D_BUS = `ERS_BLK_D_BUS_CYCLES,
  parameter int SEC_OP = `ERS_SEC_OP_CYCLES,
  parameter int SEC_BUS = `ERS_SEC_BUS_CYCLES,
  parameter int OP_DIV = `BUS_CLOCK_KHZ / `MEMORY_OP_CLOCK_KHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output flash_erase_pkg::axi_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output flash_erase_pkg::axi_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_allows_erase,
  input wire logic pflash_protect_any,
  input wire logic eeprom_protect_any,
  input wire logic verify_error,
  input wire logic verify_uncorrectable,
  input wire logic [1:0] security_state_field,
  input wire logic backdoor_unsecured,
  output logic erase_active,
  output logic verify_active,
  output logic erase_sector,
  output logic erase_eeprom,
  output logic [23:0] erase_addr,
  output logic secured
);
  import flash_erase_pkg::*;

  localparam int OPW = 17;
  localparam int BUSW = 16;
  localparam int DIVW = 8;

  // Bus slave state
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  axi_resp_t bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  axi_resp_t rresp_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Sequencer state
  seq_state_e state_reg;
  logic [2:0] param_index_reg;
  logic complete_reg;
  logic access_err_reg;
  logic prot_viol_reg;
  logic verify_any_reg;
  logic verify_uncorr_reg;
  logic seen_err_reg;
  logic seen_uncorr_reg;
  logic [OPW-1:0] op_cnt_reg;
  logic [OPW-1:0] op_target_reg;
  logic [BUSW-1:0] bus_cnt_reg;
  logic [BUSW-1:0] bus_target_reg;
  logic [DIVW-1:0] div_cnt_reg;
  logic sector_reg;
  logic eeprom_reg;
  logic [23:0] addr_reg;
  logic [1:0] sec_field_reg;
  logic secured_reg;

  // Write path decode; a write fires once address and data are both held
  wire wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  wire w_upper_zero = (waddr_reg[ADDR_W-1:6] == '0);
  wire [3:0] w_idx = waddr_reg[5:2];
  wire wr_status = wr_fire && w_upper_zero
                   && (w_idx == `IDX_MEMORY_STATUS) && wstrb_reg[0];
  wire wr_index = wr_fire && w_upper_zero
                  && (w_idx == `IDX_COMMAND_PARAM_INDEX) && wstrb_reg[0];
  wire wr_data = wr_fire && w_upper_zero
                 && (w_idx == `IDX_COMMAND_PARAM_DATA);
  wire w_mapped = w_upper_zero && ((w_idx == `IDX_MEMORY_STATUS)
                  || (w_idx == `IDX_COMMAND_PARAM_INDEX)
                  || (w_idx == `IDX_COMMAND_PARAM_DATA)
                  || (w_idx == `IDX_SECURITY));

  wire busy = !complete_reg;
  wire idle = (state_reg == ST_IDLE);

  // Parameter array, one 16-bit word per entry
  logic [16*NUM_PARAMS-1:0] param_flat;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PARAMS; gi++) begin : g_param
      logic [15:0] word_reg;
      wire sel = wr_data && !busy && (param_index_reg == 3'(gi));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          word_reg <= 16'h0000;
        end else if (sel) begin
          if (wstrb_reg[0]) word_reg[7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1]) word_reg[15:8] <= wdata_reg[15:8];
        end
      end
      assign param_flat[16*gi +: 16] = word_reg;
    end
  endgenerate

  wire [15:0] param_word_0 = param_flat[15:0];
  wire [15:0] param_word_1 = param_flat[31:16];
  wire [15:0] cur_param = (32'(param_index_reg) < NUM_PARAMS)
                          ? param_flat[16*param_index_reg +: 16]
                          : 16'h0000;

  // Command decode of the loaded parameters
  wire [7:0] cmd_code = param_word_0[15:8];
  wire [23:0] cmd_addr = {param_word_0[7:0], param_word_1};
  wire is_blk = (cmd_code == `CMD_ERASE_BLOCK);
  wire is_sec = (cmd_code == `CMD_ERASE_SECTOR);
  wire [23:0] pf_off = cmd_addr - PF_BASE;
  wire [23:0] ee_off = cmd_addr - EE_BASE;
  wire in_pf = (cmd_addr >= PF_BASE) && (pf_off < PF_SIZE);
  wire in_ee = (cmd_addr >= EE_BASE) && (ee_off < EE_SIZE);

  // Launch is a one written to the complete bit while it is set
  wire launch = wr_status && wdata_reg[`STAT_COMPLETE_BIT]
                && complete_reg && idle
                && !access_err_reg && !prot_viol_reg;
  wire err_index = (param_index_reg != `REQUIRED_PARAM_INDEX);
  wire err_mode = !mode_allows_erase || !(is_blk || is_sec);
  // A sector erase only exists in program memory
  wire err_addr = !(in_pf || (in_ee && is_blk));
  wire err_align = (in_pf && (cmd_addr[2:0] != 3'h0))
                   || (in_ee && cmd_addr[0]);
  wire acc_err = err_index || err_mode || err_addr || err_align;
  wire prot_err = is_blk && ((in_pf && pflash_protect_any)
                  || (in_ee && eeprom_protect_any));
  wire start = launch && !acc_err && !prot_err;

  // Operation length selection
  wire [OPW-1:0] op_sel = is_sec ? OPW'(SEC_OP)
                          : in_ee ? OPW'(BLK_D_OP)
                          : OPW'(BLK_P_OP);
  wire [BUSW-1:0] bus_sel = is_sec ? BUSW'(SEC_BUS)
                            : in_ee ? BUSW'(BLK_D_BUS)
                            : BUSW'(BLK_P_BUS);

  // Memory-operation clock as a tick every OP_DIV bus cycles
  wire op_tick = (div_cnt_reg == DIVW'(OP_DIV - 1));
  wire erase_last = (state_reg == ST_ERASE) && op_tick
                    && (op_cnt_reg == op_target_reg - 1'b1);
  wire verify_last = (state_reg == ST_VERIFY)
                     && (bus_cnt_reg == bus_target_reg - 1'b1);

  // Status flag clears: write one to clear; a set in the same cycle wins
  wire clr_acc = wr_status && wdata_reg[`STAT_ACCESS_ERR_BIT];
  wire clr_prot = wr_status && wdata_reg[`STAT_PROT_VIOL_BIT];
  wire any_verify_err = verify_error || verify_uncorrectable;

  // Read data decode
  wire r_upper_zero = (s_axi_araddr[ADDR_W-1:6] == '0);
  wire [3:0] r_idx = s_axi_araddr[5:2];
  wire [31:0] status_word = {24'h000000, complete_reg, 1'b0,
                             access_err_reg, prot_viol_reg, 2'h0,
                             verify_any_reg, verify_uncorr_reg};
  wire [31:0] index_word = {29'h00000000, param_index_reg};
  wire [31:0] data_word = {16'h0000, cur_param};
  wire [31:0] sec_word = {29'h00000000, secured_reg, sec_field_reg};
  wire r_status = r_upper_zero && (r_idx == `IDX_MEMORY_STATUS);
  wire r_index = r_upper_zero && (r_idx == `IDX_COMMAND_PARAM_INDEX);
  wire r_data = r_upper_zero && (r_idx == `IDX_COMMAND_PARAM_DATA);
  wire r_sec = r_upper_zero && (r_idx == `IDX_SECURITY);
  wire r_mapped = r_status || r_index || r_data || r_sec;
  wire [31:0] rd_mux = r_status ? status_word
                       : r_index ? index_word
                       : r_data ? data_word
                       : r_sec ? sec_word
                       : 32'h00000000;

  // Security decode; backdoor unsecure overrides the stored field
  wire [1:0] sec_eff = backdoor_unsecured ? `SEC_UNSECURED
                       : security_state_field;

  // Write address and data channels, taken in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready_reg <= 1'b1;
      waddr_reg <= '0;
    end else if (s_axi_awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      waddr_reg <= s_axi_awaddr;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wready_reg <= 1'b1;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Parameter index; frozen while a command runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      param_index_reg <= `PARAM_INDEX_RESET;
    end else if (wr_index && !busy) begin
      param_index_reg <= wdata_reg[2:0];
    end
  end

  // Complete flag: cleared by a good launch, set when verify ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      complete_reg <= `COMPLETE_RESET;
    end else if (verify_last) begin
      complete_reg <= 1'b1;
    end else if (start) begin
      complete_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      access_err_reg <= 1'b0;
      prot_viol_reg <= 1'b0;
    end else begin
      access_err_reg <= (launch && acc_err)
                        || (access_err_reg && !clr_acc);
      prot_viol_reg <= (launch && !acc_err && prot_err)
                       || (prot_viol_reg && !clr_prot);
    end
  end

  // Sequencer: erase phase on operation ticks, verify phase on bus cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (start) state_reg <= ST_ERASE;
        ST_ERASE: if (erase_last) state_reg <= ST_VERIFY;
        ST_VERIFY: if (verify_last) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Divider restarts at launch so the erase phase is exact
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= '0;
    end else if (start || op_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_cnt_reg <= '0;
      op_target_reg <= '0;
      bus_cnt_reg <= '0;
      bus_target_reg <= '0;
    end else if (start) begin
      op_cnt_reg <= '0;
      op_target_reg <= op_sel;
      bus_cnt_reg <= '0;
      bus_target_reg <= bus_sel;
    end else begin
      if (state_reg == ST_ERASE && op_tick) op_cnt_reg <= op_cnt_reg + 1'b1;
      if (state_reg == ST_VERIFY) bus_cnt_reg <= bus_cnt_reg + 1'b1;
    end
  end

  // Target of the running command, held for the array
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sector_reg <= 1'b0;
      eeprom_reg <= 1'b0;
      addr_reg <= 24'h000000;
    end else if (start) begin
      sector_reg <= is_sec;
      eeprom_reg <= in_ee;
      addr_reg <= cmd_addr;
    end
  end

  // Verify results collect over the pass and post at its end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_err_reg <= 1'b0;
      seen_uncorr_reg <= 1'b0;
    end else if (start) begin
      seen_err_reg <= 1'b0;
      seen_uncorr_reg <= 1'b0;
    end else if (state_reg == ST_VERIFY) begin
      seen_err_reg <= seen_err_reg || any_verify_err;
      seen_uncorr_reg <= seen_uncorr_reg || verify_uncorrectable;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      verify_any_reg <= 1'b0;
      verify_uncorr_reg <= 1'b0;
    end else if (start) begin
      verify_any_reg <= 1'b0;
      verify_uncorr_reg <= 1'b0;
    end else if (verify_last) begin
      verify_any_reg <= seen_err_reg || any_verify_err;
      verify_uncorr_reg <= seen_uncorr_reg || verify_uncorrectable;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_field_reg <= 2'h0;
      secured_reg <= 1'b1;
    end else begin
      sec_field_reg <= sec_eff;
      secured_reg <= (sec_eff != `SEC_UNSECURED);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign erase_active = state_reg[1];
  assign verify_active = state_reg[2];
  assign erase_sector = sector_reg;
  assign erase_eeprom = eeprom_reg;
  assign erase_addr = addr_reg;
  assign secured = secured_reg;

endmodule : flash_erase_command_sequencer

// >>> hw/flash_erase_params.svh
// Offsets, field positions, reset values and cycle counts of the erase
// command sequencer. Assumes an AXI4-Lite slave with 32-bit aligned words.
`ifndef FLASH_ERASE_PARAMS_SVH
`define FLASH_ERASE_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_MEMORY_STATUS 4'h0
`define IDX_COMMAND_PARAM_INDEX 4'h2
`define IDX_COMMAND_PARAM_DATA 4'h4
`define IDX_SECURITY 4'h6

// Status register field positions
`define STAT_COMPLETE_BIT 7
`define STAT_ACCESS_ERR_BIT 5
`define STAT_PROT_VIOL_BIT 4
`define STAT_VERIFY_ANY_BIT 1
`define STAT_VERIFY_UNCORR_BIT 0

// Security register field positions
`define SEC_SECURED_BIT 2

// Reset values
`define COMPLETE_RESET 1'b1
`define PARAM_INDEX_RESET 3'h0

// Command codes, launch requirement and unsecured security value
`define CMD_ERASE_BLOCK 8'h09
`define CMD_ERASE_SECTOR 8'h0A
`define REQUIRED_PARAM_INDEX 3'h1
`define SEC_UNSECURED 2'h2

// Operation lengths: memory-operation cycles and bus cycles
`define ERS_BLK_P_OP_CYCLES 100060
`define ERS_BLK_P_BUS_CYCLES 33681
`define ERS_BLK_D_OP_CYCLES 100060
`define ERS_BLK_D_BUS_CYCLES 1154
`define ERS_SEC_OP_CYCLES 20015
`define ERS_SEC_BUS_CYCLES 914

// Clock rates in kHz
`define BUS_CLOCK_KHZ 25000
`define MEMORY_OP_CLOCK_KHZ 1000

`endif

// >>> hw/flash_erase_pkg.sv
// Types shared by the erase command sequencer.
// Assumes nothing beyond a SystemVerilog package scope.
package flash_erase_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_VERIFY = 3'b100
  } seq_state_e;

  typedef logic [1:0] axi_resp_t;

  localparam axi_resp_t RESP_OKAY = 2'h0;
  localparam axi_resp_t RESP_SLVERR = 2'h2;

endpackage : flash_erase_pkg
